// file: hdl/pit_prescaler.sv
/*
 * Prescaler for the interval timer: emits a one-cycle step pulse once
 * every (scale + 1) clock cycles.
 * Assumes one clock, synchronous active-high reset, and that the owner
 * restarts the interval whenever the down-counter is rewritten.
 */
`timescale 1ns/1ps
`include "pit_params.svh"

module pit_prescaler
    import pit_pkg::*;
#(
    parameter int SCALE_W = `PIT_SCALE_W
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_run,
    input wire logic i_restart,
    input wire logic [SCALE_W-1:0] i_scale,
    output logic o_step
);
    logic [SCALE_W-1:0] phase_r;
    logic [SCALE_W-1:0] phase_nxt;
    logic step_now;

    // step every v+1 cycles
    // >= rather than == so that lowering the scale never strands the phase
    assign step_now = i_run && !i_restart && (phase_r >= i_scale);
    assign o_step = step_now;

    always_comb begin
        phase_nxt = phase_r;
        if (i_restart || !i_run || step_now) begin
            phase_nxt = '0;
        end else begin
            phase_nxt = phase_r + {{(SCALE_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            phase_r <= '0;
        end else begin
            phase_r <= phase_nxt;
        end
    end

endmodule

// file: hdl/pit_top.sv
/*
 * Prescaled interval timer: a 16-bit down-counter stepped by an 8-bit
 * prescaler, reloaded from a period register on reaching zero, with a
 * sticky interrupt status, clear and enable registers and one level
 * interrupt output.
 * Assumes a single 250 MHz clock, synchronous active-high reset, and a
 * plain register port whose strobes are one cycle long and never both
 * high at once; read data appear one cycle after the read strobe.
 */
//
// Contract
// - The 16-bit down-counter decreases by one only once every n cycles.
// - The 8-bit prescale register holds n-1, so a value v steps every v+1 cycles.
// - A timer interrupt is raised each time the down-counter reaches zero.
// - On reaching zero the counter reloads from the 16-bit period register.
`timescale 1ns/1ps
`include "pit_params.svh"

module pit_top
    import pit_pkg::*;
#(
    parameter int CNT_W = `PIT_CNT_W,
    parameter int SCALE_W = `PIT_SCALE_W
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire pit_pkg::pit_addr_t i_addr,
    input wire pit_pkg::pit_data_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output pit_pkg::pit_data_t o_rdata,
    output logic o_irq
);
    import pit_pkg::*;

    localparam int DW = `PIT_DATA_W;
    localparam int IRQ_N = `PIT_IRQ_NUM;

    // timer registers
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic [SCALE_W-1:0] scale_r;
    logic [SCALE_W-1:0] scale_nxt;
    logic [CNT_W-1:0] period_r;
    logic [CNT_W-1:0] period_nxt;
    logic run_r;
    logic run_nxt;

    // interrupt registers
    pit_irq_t irq_stat_r;
    pit_irq_t irq_stat_nxt;
    pit_irq_t irq_en_r;
    pit_irq_t irq_en_nxt;
    pit_irq_t irq_event;
    pit_irq_t irq_clear;
    pit_irq_t irq_pend;
    logic irq_r;
    logic irq_nxt;

    // read path
    pit_data_t rdata_r;
    pit_data_t rdata_nxt;
    pit_data_t rd_mux;
    // zero-extended readback words, one per readable register
    pit_data_t rd_count;
    pit_data_t rd_scale;
    pit_data_t rd_period;
    pit_data_t rd_ctrl;
    pit_data_t rd_stat;
    pit_data_t rd_en;

    // address decode
    pit_sel_t sel;
    logic hit_count;
    logic hit_scale;
    logic hit_period;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_clr;
    logic hit_en;

    logic wr_count;
    logic wr_scale;
    logic wr_period;
    logic wr_ctrl;
    logic wr_clr;
    logic wr_en;

    // counting path
    logic step;
    logic at_end;
    logic reach_zero;
    logic [CNT_W-1:0] count_dec;

    // exact byte offsets; nothing aliases across the address space
    assign hit_count = (i_addr == `PIT_OFS_COUNT);
    assign hit_scale = (i_addr == `PIT_OFS_SCALE);
    assign hit_period = (i_addr == `PIT_OFS_PERIOD);
    assign hit_ctrl = (i_addr == `PIT_OFS_CTRL);
    assign hit_stat = (i_addr == `PIT_OFS_IRQ_STAT);
    assign hit_clr = (i_addr == `PIT_OFS_IRQ_CLR);
    assign hit_en = (i_addr == `PIT_OFS_IRQ_EN);

    always_comb begin
        if (hit_count) begin
            sel = PIT_SEL_COUNT;
        end else if (hit_scale) begin
            sel = PIT_SEL_SCALE;
        end else if (hit_period) begin
            sel = PIT_SEL_PERIOD;
        end else if (hit_ctrl) begin
            sel = PIT_SEL_CTRL;
        end else if (hit_stat) begin
            sel = PIT_SEL_IRQ_STAT;
        end else if (hit_clr) begin
            sel = PIT_SEL_IRQ_CLR;
        end else if (hit_en) begin
            sel = PIT_SEL_IRQ_EN;
        end else begin
            sel = PIT_SEL_NONE;
        end
    end

    // writes to the status register and to unmapped offsets are dropped
    // software write access
    assign wr_count = i_wr && (sel == PIT_SEL_COUNT);
    assign wr_scale = i_wr && (sel == PIT_SEL_SCALE);
    assign wr_period = i_wr && (sel == PIT_SEL_PERIOD);
    assign wr_ctrl = i_wr && (sel == PIT_SEL_CTRL);
    assign wr_clr = i_wr && (sel == PIT_SEL_IRQ_CLR);
    assign wr_en = i_wr && (sel == PIT_SEL_IRQ_EN);

    // a stopped prescaler parks at phase 0, so starting the timer acts as a restart
    // counter write restarts prescale
    pit_prescaler #(
        .SCALE_W(SCALE_W)
    ) u_prescaler (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_run(run_r),
        .i_restart(wr_count),
        .i_scale(scale_r),
        .o_step(step)
    );

    // a counter already at zero (written by software) also reloads on
    // its next step rather than wrapping to all ones
    assign at_end = (count_r <= {{(CNT_W-1){1'b0}}, 1'b1});
    assign count_dec = count_r - {{(CNT_W-1){1'b0}}, 1'b1};
    assign reach_zero = step && at_end;

    always_comb begin
        count_nxt = count_r;
        if (wr_count) begin
            count_nxt = i_wdata[CNT_W-1:0];
        end else if (reach_zero) begin
            count_nxt = period_r;
        end else if (step) begin
            count_nxt = count_dec;
        end
    end

    assign scale_nxt = wr_scale ? i_wdata[SCALE_W-1:0] : scale_r;
    assign period_nxt = wr_period ? i_wdata[CNT_W-1:0] : period_r;
    assign run_nxt = wr_ctrl ? i_wdata[`PIT_CTRL_RUN_BIT] : run_r;
    assign irq_en_nxt = wr_en ? i_wdata[IRQ_N-1:0] : irq_en_r;

    // event 1 flags a zero crossing while the previous one is still pending
    assign irq_event[`PIT_IRQ_ZERO_BIT] = reach_zero;
    assign irq_event[`PIT_IRQ_OVER_BIT] = reach_zero && irq_stat_r[`PIT_IRQ_ZERO_BIT];
    // write one to clear; zero bits leave their flag alone
    assign irq_clear = wr_clr ? i_wdata[IRQ_N-1:0] : '0;

    genvar gi;
    generate
        for (gi = 0; gi < IRQ_N; gi++) begin : g_stat
            assign irq_stat_nxt[gi] = irq_event[gi] | (irq_stat_r[gi] & ~irq_clear[gi]);
            assign irq_pend[gi] = irq_stat_nxt[gi] & irq_en_nxt[gi];
        end
    endgenerate

    // next-state status used so the line rises in the same cycle as the flag
    assign irq_nxt = |irq_pend;

    assign rd_count = {{(DW-CNT_W){1'b0}}, count_r};
    assign rd_scale = {{(DW-SCALE_W){1'b0}}, scale_r};
    assign rd_period = {{(DW-CNT_W){1'b0}}, period_r};
    assign rd_ctrl = {{(DW-1){1'b0}}, run_r} << `PIT_CTRL_RUN_BIT;
    assign rd_stat = {{(DW-IRQ_N){1'b0}}, irq_stat_r};
    assign rd_en = {{(DW-IRQ_N){1'b0}}, irq_en_r};

    always_comb begin
        rd_mux = '0;
        case (sel)
            PIT_SEL_COUNT: begin
                rd_mux = rd_count;
            end
            PIT_SEL_SCALE: begin
                rd_mux = rd_scale;
            end
            PIT_SEL_PERIOD: begin
                rd_mux = rd_period;
            end
            PIT_SEL_CTRL: begin
                rd_mux = rd_ctrl;
            end
            PIT_SEL_IRQ_STAT: begin
                rd_mux = rd_stat;
            end
            PIT_SEL_IRQ_EN: begin
                rd_mux = rd_en;
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    // read data stand for exactly one cycle, zero otherwise
    // software read access
    assign rdata_nxt = i_rd ? rd_mux : '0;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            count_r <= `PIT_RST_COUNT;
        end else begin
            count_r <= count_nxt;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            scale_r <= `PIT_RST_SCALE;
        end else begin
            scale_r <= scale_nxt;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            period_r <= `PIT_RST_PERIOD;
        end else begin
            period_r <= period_nxt;
        end
    end

    // clearing run freezes the counter and parks the prescale phase
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            run_r <= `PIT_RST_CTRL;
        end else begin
            run_r <= run_nxt;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            irq_stat_r <= `PIT_RST_IRQ;
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    // enable shares the status layout
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            irq_en_r <= `PIT_RST_IRQ;
        end else begin
            irq_en_r <= irq_en_nxt;
        end
    end

    // registered so the pin never glitches on decode
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    // zero outside the answer cycle so stale data never linger on the bus
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign o_rdata = rdata_r;
    assign o_irq = irq_r;

endmodule

// file: shared/pit_params.svh
/*
 * Offsets, field positions, reset values and widths for the prescaled
 * interval timer. Included by the timer package users; no logic here.
 */
`ifndef PIT_PARAMS_SVH
`define PIT_PARAMS_SVH

// register offsets, byte addresses on the plain register port
`define PIT_OFS_COUNT 8'h00
`define PIT_OFS_SCALE 8'h04
`define PIT_OFS_PERIOD 8'h08
`define PIT_OFS_CTRL 8'h0c
`define PIT_OFS_IRQ_STAT 8'h10
`define PIT_OFS_IRQ_CLR 8'h14
`define PIT_OFS_IRQ_EN 8'h18

// control register fields
`define PIT_CTRL_RUN_BIT 0

// interrupt status, clear and enable fields (same layout)
`define PIT_IRQ_ZERO_BIT 0
`define PIT_IRQ_OVER_BIT 1
`define PIT_IRQ_NUM 2

// reset values
`define PIT_RST_COUNT 16'h0000
`define PIT_RST_SCALE 8'h00
`define PIT_RST_PERIOD 16'h0000
`define PIT_RST_CTRL 1'b0
`define PIT_RST_IRQ 2'h0

// widths
`define PIT_CNT_W 16
`define PIT_SCALE_W 8
`define PIT_ADDR_W 8
`define PIT_DATA_W 32

`endif

// file: shared/pit_pkg.sv
/*
 * Types shared by the prescaled interval timer modules.
 * Assumes pit_params.svh is on the include path.
 */
`include "pit_params.svh"

package pit_pkg;

    typedef logic [`PIT_ADDR_W-1:0] pit_addr_t;
    typedef logic [`PIT_DATA_W-1:0] pit_data_t;
    typedef logic [`PIT_CNT_W-1:0] pit_cnt_t;
    typedef logic [`PIT_SCALE_W-1:0] pit_scale_t;
    typedef logic [`PIT_IRQ_NUM-1:0] pit_irq_t;

    // register selected by the current bus address
    typedef enum {
        PIT_SEL_COUNT,
        PIT_SEL_SCALE,
        PIT_SEL_PERIOD,
        PIT_SEL_CTRL,
        PIT_SEL_IRQ_STAT,
        PIT_SEL_IRQ_CLR,
        PIT_SEL_IRQ_EN,
        PIT_SEL_NONE
    } pit_sel_t;

endpackage

// file: sim/pit_top_chk.sv
/* checker for the interval timer register port and interrupt output.
   sees only pit_top ports; bound from the bench top file. */
`timescale 1ns/1ps
module pit_top_chk
    import pit_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire pit_pkg::pit_addr_t i_addr,
    input wire pit_pkg::pit_data_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire pit_pkg::pit_data_t o_rdata,
    input wire logic o_irq
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    // shadow copies so readback can be judged without the design's state
    logic [15:0] per_r;
    logic [7:0] scl_r;
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            per_r <= 16'h0000;
            scl_r <= 8'h00;
        end else if (i_wr && i_addr == 8'h08) begin
            per_r <= i_wdata[15:0];
        end else if (i_wr && i_addr == 8'h04) begin
            scl_r <= i_wdata[7:0];
        end
    end
    sequence s_cnt_wr;
        i_wr && i_addr == 8'h00;
    endsequence
    sequence s_cnt_rd;
        i_rd && i_addr == 8'h00;
    endsequence
    property p_cnt_back;
        s_cnt_wr ##1 s_cnt_rd |=> o_rdata == {16'h0000, $past(i_wdata[15:0], 2)};
    endproperty
    a_cnt_back: assert property (p_cnt_back) else $error("count readback wrong");
    property p_per_rd;
        i_rd && i_addr == 8'h08 |=> o_rdata == {16'h0000, per_r};
    endproperty
    a_per_rd: assert property (p_per_rd) else $error("period readback wrong");
    property p_scl_rd;
        i_rd && i_addr == 8'h04 |=> o_rdata == {24'h000000, scl_r};
    endproperty
    a_scl_rd: assert property (p_scl_rd) else $error("prescale readback wrong");
    property p_idle;
        !i_rd |=> o_rdata == 32'h00000000;
    endproperty
    a_idle: assert property (p_idle) else $error("read data without read");
    property p_irq_fall;
        $fell(o_irq) |-> $past(i_wr);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped unasked");
endmodule

// file: sim/pit_top_tb_top.sv
/* bench for the prescaled interval timer: drives the register port and
   judges read data and the interrupt. assumes pit_top and pit_top_chk. */
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module pit_top_tb_top
    import pit_pkg::*;
;
    logic i_clk_sys = 1'b0;
    logic i_reset = 1'b1;
    pit_addr_t i_addr = 8'h00;
    pit_data_t i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    pit_data_t o_rdata;
    logic o_irq;
    pit_data_t v;
    int bad_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int t0;
    pit_top i_pit_top (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq));
    initial begin
        forever #2 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) cyc <= cyc + 1;
    // strobes rise just after one edge and drop at the next; two calls in a
    // row leave an idle cycle, and tasks return at the falling edge
    task automatic wr(input pit_addr_t a, input pit_data_t d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        @(negedge i_clk_sys);
    endtask
    // read data stand only in the cycle after the strobe, taken mid-cycle
    task automatic rd(input pit_addr_t a);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        @(negedge i_clk_sys);
        v = o_rdata;
    endtask
    // write then read back the same offset with no gap between strobes
    task automatic wr_rd(input pit_addr_t a, input pit_data_t d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        @(negedge i_clk_sys);
        v = o_rdata;
    endtask
    task automatic wait_irq();
        int n = 0;
        while (o_irq !== 1'b1 && n < 2000) begin
            @(negedge i_clk_sys);
            n++;
        end
        `CHK(n < 2000, 1'b1)
    endtask
    task automatic t_regs();
        for (int a = 0; a < 32; a += 4) begin
            rd(a[7:0]);
            `CHK(v, 32'h0)
        end
        wr(8'h04, 32'hffffffa5);
        wr(8'h08, 32'hffff1234);
        wr(8'h10, 32'h3);
        wr(8'h1c, 32'h5a5a);
        wr_rd(8'h00, 32'hffff0bcd);
        `CHK(v, 32'h00000bcd)
        rd(8'h04);
        `CHK(v, 32'h000000a5)
        rd(8'h08);
        `CHK(v, 32'h00001234)
        rd(8'h10);
        `CHK(v, 32'h0)
        rd(8'h1c);
        `CHK(v, 32'h0)
    endtask
    // count is loaded while stopped, so the start write alone sets the phase
    task automatic t_mask();
        wr(8'h04, 32'h0);
        wr(8'h08, 32'h2);
        wr(8'h00, 32'h1);
        wr(8'h0c, 32'h1);
        repeat (3) @(negedge i_clk_sys);
        `CHK(o_irq, 1'b0)
        rd(8'h10);
        `CHK(v, 32'h3)
        wr(8'h18, 32'h1);
        `CHK(o_irq, 1'b1)
        wr(8'h0c, 32'h0);
        wr(8'h14, 32'h3);
        `CHK(o_irq, 1'b0)
    endtask
    task automatic t_timing();
        int scl[3] = '{0, 2, 255};
        int per[3] = '{7, 4, 2};
        for (int k = 0; k < 3; k++) begin
            wr(8'h04, scl[k]);
            wr(8'h08, per[k]);
            wr(8'h00, 32'h1);
            wr(8'h14, 32'h3);
            wr(8'h0c, 32'h1);
            t0 = cyc;
            wait_irq();
            `CHK(cyc - t0, scl[k] + 1)
            t0 = cyc;
            // a zero scale steps once more before the read is taken
            rd(8'h00);
            `CHK(v, per[k] - (scl[k] == 0 ? 1 : 0))
            wr(8'h14, 32'h1);
            wait_irq();
            `CHK(cyc - t0, per[k] * (scl[k] + 1))
            wr(8'h14, 32'h1);
            wr(8'h00, 32'h1);
            t0 = cyc;
            wait_irq();
            `CHK(cyc - t0, scl[k] + 1)
            wr(8'h0c, 32'h0);
        end
    endtask
    task automatic end_of_test();
        $display("checks=%0d bad=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        @(posedge i_clk_sys);
        t_regs();
        t_mask();
        t_timing();
        end_of_test();
    end
    // whole run needs a few thousand cycles at most
    initial begin
        #40000;
        bad_count++;
        end_of_test();
    end
endmodule
bind pit_top pit_top_chk i_pit_top_chk (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_irq(o_irq));
